/* File: logic/tfm_firing_status.sv */
// Mode, firing enable, setpoint source, inhibit and status indicator logic of the firing controller.
// Summary of operation
// - Healthy LED toggles while firmware keeps kicking; stops when kicks cease.
// - Inhibit LED lights when the fast inhibit or any enabled soft inhibit source is active.
// - Line-sync-loss LED lights while the PLL is not locked.
// - Fault LED lights while any fault is present, dark otherwise.
// - Three-controller modes 6 and 7: all three inhibited gives steady lit LED.
// - Three-controller modes: none inhibited gives steady dark LED.
// - Three-controller modes: one or two inhibited flash that many times per group.
// - Single-controller modes: inhibit LED steady lit while inhibited, else dark.
// - Operating mode register picks phase, zero-cross, voltage or current operation.
// - Mode value zero runs three-phase AC controller with open-loop phase control.
// - Mode value 8 runs single-phase bridge converter with phase control.
// - Mode value 6 runs up to three single-phase phase-control AC controllers.
// - A gate channel fires only when its channel enable bit is one.
// - With several controllers, fast inhibit suppresses firing on every channel.
// - Soft inhibit pin inhibits its controller only when enabled in register.
// - Source register picks analog input or setpoint register as angle command.
// - Each analog input is 0-5V, 0-10V, 4-20mA or 0-20mA per config register.
// - Voltage input: 0V gives maximum angle, full scale gives minimum angle.
// - Current input: 0mA or 4mA gives maximum angle, 20mA minimum angle.
// - Analog input is fixed or picked between two by a digital pin level.
// - Each of three controllers has its own setpoint, source and input select.
// - Zero command means 180 degrees, full command means zero degrees.
`timescale 1ns/10ps
`default_nettype none
`include "tfm_defines.svh"
module tfm_firing_status
  import tfm_pkg::*;
#(
  parameter int unsigned HEALTHY_HALF_CYCLES = `TFM_MS_TO_CYCLES(`TFM_HEALTHY_HALF_MS),
  parameter int unsigned WDOG_CYCLES = `TFM_MS_TO_CYCLES(`TFM_WDOG_MS),
  parameter int unsigned FLASH_ON_CYCLES = `TFM_MS_TO_CYCLES(`TFM_FLASH_ON_MS),
  parameter int unsigned FLASH_OFF_CYCLES = `TFM_MS_TO_CYCLES(`TFM_FLASH_OFF_MS),
  parameter int unsigned PAUSE_CYCLES = `TFM_MS_TO_CYCLES(`TFM_GROUP_PAUSE_MS)
) (
  input wire logic i_clock, // System clock, 100 MHz.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic i_reg_wr, // Register write strobe.
  input wire logic i_reg_rd, // Register read strobe.
  input wire logic [15:0] i_reg_addr, // Register address.
  input wire logic [15:0] i_reg_wdata, // Register write data.
  output logic [15:0] o_reg_rdata, // Register read data.
  output logic o_reg_ack, // Access done, one cycle.
  output logic o_reg_err, // Access hit no register, with ack.
  input wire logic i_firmware_kick, // Control firmware alive pulse.
  input wire logic i_fault_active, // Any fault present.
  input wire logic i_pll_locked, // Line PLL in lock.
  input wire logic i_fast_inhibit_pin, // Fast inhibit pin, high inhibits.
  input wire logic [2:0] i_soft_inhibit_pin, // Soft inhibit pin per controller.
  input wire logic i_ain_select_pin, // Picks the alternate analog input.
  input wire logic [11:0] i_ain0_code, // Analog input 1 sample.
  input wire logic [11:0] i_ain1_code, // Analog input 2 sample.
  input wire logic [11:0] i_ain2_code, // Analog input 3 sample.
  output logic [5:0] o_gate_enable, // Firing permitted per channel.
  output logic [3:0] o_mode_kind, // One-hot operation kind.
  output logic o_multi_controller, // Three-controller mode active.
  output logic [11:0] o_firing_angle0, // Controller 1 angle, full code is 180 degrees.
  output logic [11:0] o_firing_angle1, // Controller 2 angle.
  output logic [11:0] o_firing_angle2, // Controller 3 angle.
  output logic o_system_healthy_led, // Healthy LED.
  output logic o_inhibit_led, // Inhibit LED.
  output logic o_line_sync_loss_led, // Line sync loss LED.
  output logic o_fault_led // Fault LED.
);
  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic tfm_cmd_t ain_to_cmd(input logic [11:0] code, input logic [1:0] kind);
    logic [12:0] dbl;
    logic [11:0] lifted;
    logic [13:0] scaled;
    dbl = {code, 1'b0};
    lifted = (code > `TFM_AIN_4MA_CODE) ? code - `TFM_AIN_4MA_CODE : 12'h000;
    scaled = {2'b00, lifted} + {4'h0, lifted[11:2]};
    case (kind)
      `TFM_AIN_0_5V: begin
        ain_to_cmd = dbl[12] ? `TFM_CMD_FULL : dbl[11:0];
      end
      `TFM_AIN_4_20MA: begin
        ain_to_cmd = (scaled > {2'b00, `TFM_CMD_FULL}) ? `TFM_CMD_FULL : scaled[11:0];
      end
      default: begin
        ain_to_cmd = code;
      end
    endcase
  endfunction

  function automatic tfm_cmd_t reg_to_cmd(input logic [15:0] value);
    reg_to_cmd = (value > {4'h0, `TFM_CMD_FULL}) ? `TFM_CMD_FULL : value[11:0];
  endfunction

  function automatic logic [11:0] cmd_to_angle(input tfm_cmd_t cmd);
    cmd_to_angle = `TFM_CMD_FULL - cmd;
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [15:0] operating_mode_select;
  logic [15:0] analog_input_type_config;
  logic [15:0] soft_inhibit_pin_enable;
  logic [15:0] gate_channel_enable;
  logic [15:0] control_setpoint [3];
  logic [15:0] phase_command_source_select [3];
  logic [15:0] analog_input_select [3];
  logic [15:0] status_word;
  logic [15:0] next_rdata;
  logic next_err;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      operating_mode_select <= `TFM_OPMODE_RST;
      analog_input_type_config <= `TFM_REG_RST;
      soft_inhibit_pin_enable <= `TFM_REG_RST;
      gate_channel_enable <= `TFM_CHAN_EN_RST;
      for (int i = 0; i < 3; i++) begin
        control_setpoint[i] <= `TFM_REG_RST;
        phase_command_source_select[i] <= `TFM_REG_RST;
        analog_input_select[i] <= `TFM_REG_RST;
      end
    end else if (i_reg_wr) begin
      if (i_reg_addr == `TFM_ADDR_OPMODE) begin
        operating_mode_select <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_AIN_CFG) begin
        analog_input_type_config <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_SOFT_INH_EN) begin
        soft_inhibit_pin_enable <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_CHAN_EN) begin
        gate_channel_enable <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_SETPOINT0) begin
        control_setpoint[0] <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_SETPOINT1) begin
        control_setpoint[1] <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_SETPOINT2) begin
        control_setpoint[2] <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_SRC_SEL0) begin
        phase_command_source_select[0] <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_SRC_SEL1) begin
        phase_command_source_select[1] <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_SRC_SEL2) begin
        phase_command_source_select[2] <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_AIN_SEL0) begin
        analog_input_select[0] <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_AIN_SEL1) begin
        analog_input_select[1] <= i_reg_wdata;
      end else if (i_reg_addr == `TFM_ADDR_AIN_SEL2) begin
        analog_input_select[2] <= i_reg_wdata;
      end
    end
  end

  always_comb begin
    next_err = 1'b0;
    next_rdata = 16'h0000;
    if (i_reg_addr == `TFM_ADDR_OPMODE) begin
      next_rdata = operating_mode_select;
    end else if (i_reg_addr == `TFM_ADDR_AIN_CFG) begin
      next_rdata = analog_input_type_config;
    end else if (i_reg_addr == `TFM_ADDR_SOFT_INH_EN) begin
      next_rdata = soft_inhibit_pin_enable;
    end else if (i_reg_addr == `TFM_ADDR_CHAN_EN) begin
      next_rdata = gate_channel_enable;
    end else if (i_reg_addr == `TFM_ADDR_SETPOINT0) begin
      next_rdata = control_setpoint[0];
    end else if (i_reg_addr == `TFM_ADDR_SETPOINT1) begin
      next_rdata = control_setpoint[1];
    end else if (i_reg_addr == `TFM_ADDR_SETPOINT2) begin
      next_rdata = control_setpoint[2];
    end else if (i_reg_addr == `TFM_ADDR_SRC_SEL0) begin
      next_rdata = phase_command_source_select[0];
    end else if (i_reg_addr == `TFM_ADDR_SRC_SEL1) begin
      next_rdata = phase_command_source_select[1];
    end else if (i_reg_addr == `TFM_ADDR_SRC_SEL2) begin
      next_rdata = phase_command_source_select[2];
    end else if (i_reg_addr == `TFM_ADDR_AIN_SEL0) begin
      next_rdata = analog_input_select[0];
    end else if (i_reg_addr == `TFM_ADDR_AIN_SEL1) begin
      next_rdata = analog_input_select[1];
    end else if (i_reg_addr == `TFM_ADDR_AIN_SEL2) begin
      next_rdata = analog_input_select[2];
    end else if (i_reg_addr == `TFM_ADDR_STATUS) begin
      next_rdata = status_word;
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 16'h0000;
      o_reg_ack <= 1'b0;
      o_reg_err <= 1'b0;
    end else begin
      o_reg_ack <= i_reg_rd | i_reg_wr;
      o_reg_err <= (i_reg_rd | i_reg_wr) & next_err;
      if (i_reg_rd) begin
        o_reg_rdata <= next_err ? 16'h0000 : next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  tfm_kind_t kind;
  logic multi;

  always_comb begin
    multi = 1'b0;
    kind = TFM_KIND_PHASE;
    case (operating_mode_select)
      `TFM_MODE_3PH_AC_PHASE: begin
        kind = TFM_KIND_PHASE;
      end
      `TFM_MODE_1PH_BRIDGE_PHASE: begin
        kind = TFM_KIND_PHASE;
      end
      `TFM_MODE_1PH_MULTI_PHASE: begin
        kind = TFM_KIND_PHASE;
        multi = 1'b1;
      end
      `TFM_MODE_1PH_MULTI_ZERO: begin
        kind = TFM_KIND_ZERO;
        multi = 1'b1;
      end
      `TFM_MODE_3PH_ZERO: begin
        kind = TFM_KIND_ZERO;
      end
      `TFM_MODE_VOLTAGE: begin
        kind = TFM_KIND_VOLTAGE;
      end
      `TFM_MODE_CURRENT: begin
        kind = TFM_KIND_CURRENT;
      end
      default: begin
        kind = TFM_KIND_PHASE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Pin synchronisation and inhibit
  // ----------------------------------------------------------------------
  logic fast_inh;
  logic [2:0] soft_pin;
  logic sel_pin;
  logic [2:0] ctl_inh;
  logic any_inh;
  logic [1:0] inh_count;

  tfm_sync #(
    .WIDTH(5)
  ) u_pin_sync (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_async({i_ain_select_pin, i_soft_inhibit_pin, i_fast_inhibit_pin}),
    .o_sync({sel_pin, soft_pin, fast_inh})
  );

  // Fast inhibit reaches every controller; soft pins only count when enabled.
  assign ctl_inh = {3{fast_inh}} | (soft_pin & soft_inhibit_pin_enable[2:0]);
  assign any_inh = fast_inh | (|(soft_pin & soft_inhibit_pin_enable[2:0]));
  assign inh_count = {1'b0, ctl_inh[0]} + {1'b0, ctl_inh[1]} + {1'b0, ctl_inh[2]};

  // ----------------------------------------------------------------------
  // Gate enables
  // ----------------------------------------------------------------------
  // In three-controller modes each controller owns a pair of adjacent channels.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_gate_enable <= 6'h00;
    end else begin
      for (int ch = 0; ch < 6; ch++) begin
        o_gate_enable[ch] <= gate_channel_enable[ch] &
          (multi ? ~ctl_inh[ch / 2] : ~any_inh);
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_mode_kind <= TFM_KIND_PHASE;
      o_multi_controller <= 1'b0;
    end else begin
      o_mode_kind <= kind;
      o_multi_controller <= multi;
    end
  end

  // ----------------------------------------------------------------------
  // Command source and firing angle
  // ----------------------------------------------------------------------
  tfm_cmd_t ain_cmd [3];
  tfm_cmd_t ctl_cmd [3];
  logic [1:0] ain_index [3];
  logic [11:0] next_angle [3];

  always_comb begin
    ain_cmd[0] = ain_to_cmd(i_ain0_code, analog_input_type_config[1:0]);
    ain_cmd[1] = ain_to_cmd(i_ain1_code, analog_input_type_config[3:2]);
    ain_cmd[2] = ain_to_cmd(i_ain2_code, analog_input_type_config[5:4]);
    for (int i = 0; i < 3; i++) begin
      ain_index[i] = (analog_input_select[i][`TFM_AINSEL_DYNAMIC_BIT] && sel_pin) ?
        analog_input_select[i][5:4] : analog_input_select[i][1:0];
      if (phase_command_source_select[i][`TFM_SRC_REGISTER_BIT]) begin
        ctl_cmd[i] = reg_to_cmd(control_setpoint[i]);
      end else if (ain_index[i] == 2'h1) begin
        ctl_cmd[i] = ain_cmd[1];
      end else if (ain_index[i] == 2'h2) begin
        ctl_cmd[i] = ain_cmd[2];
      end else begin
        ctl_cmd[i] = ain_cmd[0];
      end
      // Unused controllers in single-controller modes rest at no conduction.
      next_angle[i] = (i == 0 || multi) ? cmd_to_angle(ctl_cmd[i]) : `TFM_CMD_FULL;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_firing_angle0 <= `TFM_CMD_FULL;
      o_firing_angle1 <= `TFM_CMD_FULL;
      o_firing_angle2 <= `TFM_CMD_FULL;
    end else begin
      o_firing_angle0 <= next_angle[0];
      o_firing_angle1 <= next_angle[1];
      o_firing_angle2 <= next_angle[2];
    end
  end

  // ----------------------------------------------------------------------
  // Healthy indicator
  // ----------------------------------------------------------------------
  logic [31:0] wdog_cnt;
  logic [31:0] healthy_cnt;
  logic alive;

  // The watchdog turns firmware kicks into a level, so a hung firmware freezes the LED.
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      wdog_cnt <= 32'h0000_0000;
    end else if (i_firmware_kick) begin
      wdog_cnt <= WDOG_CYCLES;
    end else if (wdog_cnt != 32'h0000_0000) begin
      wdog_cnt <= wdog_cnt - 32'h0000_0001;
    end
  end

  assign alive = (wdog_cnt != 32'h0000_0000);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      healthy_cnt <= 32'h0000_0000;
      o_system_healthy_led <= 1'b0;
    end else if (!alive) begin
      healthy_cnt <= 32'h0000_0000;
    end else if (healthy_cnt == HEALTHY_HALF_CYCLES - 1) begin
      healthy_cnt <= 32'h0000_0000;
      o_system_healthy_led <= ~o_system_healthy_led;
    end else begin
      healthy_cnt <= healthy_cnt + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Inhibit, sync loss and fault indicators
  // ----------------------------------------------------------------------
  logic blink_led;

  tfm_blink #(
    .FLASH_ON_CYCLES(FLASH_ON_CYCLES),
    .FLASH_OFF_CYCLES(FLASH_OFF_CYCLES),
    .PAUSE_CYCLES(PAUSE_CYCLES)
  ) u_blink (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_count(inh_count),
    .o_led(blink_led)
  );

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_inhibit_led <= 1'b0;
      o_line_sync_loss_led <= 1'b0;
      o_fault_led <= 1'b0;
    end else begin
      if (!multi) begin
        o_inhibit_led <= any_inh;
      end else if (inh_count == 2'h3) begin
        o_inhibit_led <= 1'b1;
      end else if (inh_count == 2'h0) begin
        o_inhibit_led <= 1'b0;
      end else begin
        o_inhibit_led <= blink_led;
      end
      o_line_sync_loss_led <= ~i_pll_locked;
      o_fault_led <= i_fault_active;
    end
  end

  assign status_word = {8'h00, alive, ~i_pll_locked, i_fault_active, fast_inh, 1'b0, ctl_inh};
endmodule // tfm_firing_status
`default_nettype wire

/* File: shared/tfm_defines.svh */
// Register offsets, field positions, reset values and timing counts of the firing status block.
`ifndef TFM_DEFINES_SVH
`define TFM_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TFM_ADDR_SETPOINT0 16'h0005
`define TFM_ADDR_SETPOINT1 16'h0006
`define TFM_ADDR_SETPOINT2 16'h0007
`define TFM_ADDR_STATUS 16'h0100
`define TFM_ADDR_OPMODE 16'h1000
`define TFM_ADDR_AIN_CFG 16'h1001
`define TFM_ADDR_SOFT_INH_EN 16'h1010
`define TFM_ADDR_SRC_SEL0 16'h1020
`define TFM_ADDR_AIN_SEL0 16'h1021
`define TFM_ADDR_SRC_SEL1 16'h1024
`define TFM_ADDR_AIN_SEL1 16'h1025
`define TFM_ADDR_SRC_SEL2 16'h1028
`define TFM_ADDR_AIN_SEL2 16'h1029
`define TFM_ADDR_CHAN_EN 16'h10a2

// ----------------------------------------------------------------------
// Operating mode values
// ----------------------------------------------------------------------
`define TFM_MODE_3PH_AC_PHASE 16'h0000
`define TFM_MODE_3PH_ZERO 16'h0001
`define TFM_MODE_VOLTAGE 16'h0002
`define TFM_MODE_CURRENT 16'h0003
`define TFM_MODE_1PH_MULTI_PHASE 16'h0006
`define TFM_MODE_1PH_MULTI_ZERO 16'h0007
`define TFM_MODE_1PH_BRIDGE_PHASE 16'h0008

// ----------------------------------------------------------------------
// Field positions and encodings
// ----------------------------------------------------------------------
`define TFM_AIN_0_10V 2'h0
`define TFM_AIN_0_5V 2'h1
`define TFM_AIN_4_20MA 2'h2
`define TFM_AIN_0_20MA 2'h3
`define TFM_SRC_REGISTER_BIT 0
`define TFM_AINSEL_DYNAMIC_BIT 2
`define TFM_CMD_FULL 12'hfff
`define TFM_AIN_4MA_CODE 12'h333

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TFM_OPMODE_RST 16'h0000
`define TFM_CHAN_EN_RST 16'h003f
`define TFM_REG_RST 16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TFM_CLK_HZ 100000000
`define TFM_HEALTHY_HALF_MS 250
`define TFM_WDOG_MS 100
`define TFM_FLASH_ON_MS 200
`define TFM_FLASH_OFF_MS 200
`define TFM_GROUP_PAUSE_MS 1000
`define TFM_MS_TO_CYCLES(ms) ((ms) * (`TFM_CLK_HZ / 1000))

`endif

/* File: shared/tfm_pkg.sv */
// Types shared by the firing status block.
package tfm_pkg;

  typedef enum logic [3:0] {
    TFM_KIND_PHASE = 4'b0001,
    TFM_KIND_ZERO = 4'b0010,
    TFM_KIND_VOLTAGE = 4'b0100,
    TFM_KIND_CURRENT = 4'b1000
  } tfm_kind_t;

  typedef enum logic [2:0] {
    TFM_BL_ON = 3'b001,
    TFM_BL_GAP = 3'b010,
    TFM_BL_PAUSE = 3'b100
  } tfm_blink_state_t;

  typedef logic [11:0] tfm_cmd_t;

endpackage

/* File: logic/tfm_sync.sv */
// Two flip-flop synchroniser for asynchronous pin levels.
`timescale 1ns/10ps
`default_nettype none
module tfm_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_clock, // System clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] i_async, // Pin levels from outside.
  output logic [WIDTH-1:0] o_sync // Levels safe to read.
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule // tfm_sync
`default_nettype wire

/* File: logic/tfm_blink.sv */
// Group flasher: shows a count of one or two as flashes followed by a long dark pause.
`timescale 1ns/10ps
`default_nettype none
`include "tfm_defines.svh"
module tfm_blink
  import tfm_pkg::*;
#(
  parameter int unsigned FLASH_ON_CYCLES = `TFM_MS_TO_CYCLES(`TFM_FLASH_ON_MS),
  parameter int unsigned FLASH_OFF_CYCLES = `TFM_MS_TO_CYCLES(`TFM_FLASH_OFF_MS),
  parameter int unsigned PAUSE_CYCLES = `TFM_MS_TO_CYCLES(`TFM_GROUP_PAUSE_MS)
) (
  input wire logic i_clock, // System clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic [1:0] i_count, // Flashes per group, 1 or 2.
  output logic o_led // Flash pattern, high is lit.
);
  tfm_blink_state_t state;
  logic [31:0] timer;
  logic [1:0] flashes;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state <= TFM_BL_PAUSE;
      timer <= 32'h0000_0000;
      flashes <= 2'h0;
    end else if (timer != 32'h0000_0000) begin
      timer <= timer - 32'h0000_0001;
    end else begin
      case (state)
        TFM_BL_ON: begin
          flashes <= flashes + 2'h1;
          state <= (flashes + 2'h1 >= i_count) ? TFM_BL_PAUSE : TFM_BL_GAP;
          timer <= (flashes + 2'h1 >= i_count) ? PAUSE_CYCLES - 1 : FLASH_OFF_CYCLES - 1;
        end
        TFM_BL_GAP: begin
          state <= TFM_BL_ON;
          timer <= FLASH_ON_CYCLES - 1;
        end
        default: begin
          flashes <= 2'h0;
          state <= TFM_BL_ON;
          timer <= FLASH_ON_CYCLES - 1;
        end
      endcase
    end
  end

  assign o_led = (state == TFM_BL_ON);
endmodule // tfm_blink
`default_nettype wire

/* File: dv/tfm_chk.sv */
// Port-level checks of the firing status block.
`timescale 1ns/10ps
`default_nettype none
module tfm_chk (
  input wire logic i_clock, // Clock.
  input wire logic i_rst_n, // Reset.
  input wire logic i_reg_wr, // Write.
  input wire logic i_reg_rd, // Read.
  input wire logic o_reg_ack, // Ack.
  input wire logic i_fault_active, // Fault.
  input wire logic o_fault_led, // Fault LED.
  input wire logic i_pll_locked, // Lock.
  input wire logic o_line_sync_loss_led, // Sync LED.
  input wire logic i_fast_inhibit_pin, // Fast pin.
  input wire logic [5:0] o_gate_enable, // Gates.
  input wire logic [3:0] o_mode_kind, // Kind.
  input wire logic o_multi_controller, // Multi.
  input wire logic o_inhibit_led, // Inhibit LED.
  input wire logic o_system_healthy_led // Healthy LED.
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  a_fault_follow: assert property (o_fault_led == $past(i_fault_active))
    else $error("fault led wrong");
  a_sync_follow: assert property (o_line_sync_loss_led != $past(i_pll_locked))
    else $error("sync loss led wrong");
  a_ack_follows: assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack)
    else $error("ack missing");
  a_ack_only: assert property (!(i_reg_wr || i_reg_rd) |=> !o_reg_ack)
    else $error("stray ack");
  a_fast_gates: assert property (i_fast_inhibit_pin [*4] |=> o_gate_enable == 6'h00)
    else $error("gates open under fast inhibit");
  a_fast_lit: assert property ((i_fast_inhibit_pin && !o_multi_controller) [*4] |=> o_inhibit_led)
    else $error("inhibit led dark");
  a_kind_onehot: assert property ($onehot(o_mode_kind))
    else $error("kind not one-hot");
  a_multi_kind: assert property (o_multi_controller |-> o_mode_kind inside {4'h1, 4'h2})
    else $error("multi with wrong kind");
  a_reset_dark: assert property ($rose(i_rst_n) |-> !(o_fault_led | o_inhibit_led |
    o_system_healthy_led | o_line_sync_loss_led)) else $error("led lit after reset");
endmodule // tfm_chk
`default_nettype wire

/* File: dv/tfm_ain_src.sv */
// Analog setpoint sources feeding the three inputs.
`timescale 1ns/10ps
`default_nettype none
module tfm_ain_src (
  input wire logic [11:0] i_level, // Level to present.
  output logic [11:0] o_ain0, // Input 1.
  output logic [11:0] o_ain1, // Input 2.
  output logic [11:0] o_ain2 // Input 3.
);
  // Distinct levels per input make a wrong input pick visible.
  assign o_ain0 = i_level;
  assign o_ain1 = ~i_level;
  assign o_ain2 = i_level ^ 12'h5a5;
endmodule // tfm_ain_src
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking testbench of the firing status block.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic i_clock = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0, i_firmware_kick = 0, h;
  logic i_fault_active = 0, i_pll_locked = 1, i_fast_inhibit_pin = 0, i_ain_select_pin = 0;
  logic [2:0] i_soft_inhibit_pin = 0;
  logic [15:0] i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata;
  logic [11:0] lvl = 0, i_ain0_code, i_ain1_code, i_ain2_code;
  logic [11:0] o_firing_angle0, o_firing_angle1, o_firing_angle2;
  logic [5:0] o_gate_enable;
  logic [3:0] o_mode_kind;
  logic o_reg_ack, o_reg_err, o_multi_controller, o_system_healthy_led;
  logic o_inhibit_led, o_line_sync_loss_led, o_fault_led;
  int num_errors = 0, compares = 0, n, k;
  int md[7] = '{0, 1, 2, 3, 6, 7, 8};
  int kd[7] = '{1, 2, 4, 8, 1, 2, 1};
  int pat[4] = '{0, 7, 4, 3};
  int lit[4] = '{0, 140, 28, 40};
  int ge[4] = '{'h3f, 0, 'h0f, 'h30};
  tfm_firing_status #(.HEALTHY_HALF_CYCLES(8), .WDOG_CYCLES(40), .FLASH_ON_CYCLES(4),
    .FLASH_OFF_CYCLES(4), .PAUSE_CYCLES(16)) tfm_firing_status_i (.*);
  tfm_ain_src tfm_ain_src_i (.i_level(lvl), .o_ain0(i_ain0_code), .o_ain1(i_ain1_code),
    .o_ain2(i_ain2_code));
  initial forever #5 i_clock = ~i_clock;
  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cyc(int c);
    repeat (c) @(posedge i_clock);
    #1;
  endtask
  // The strobe is taken at the next edge; ack and read data stand after it.
  task automatic acc(logic w, logic [15:0] a, logic [15:0] d);
    @(posedge i_clock);
    i_reg_wr <= w;
    i_reg_rd <= !w;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 0;
    i_reg_rd <= 0;
    #1;
    chk("ack", 1, o_reg_ack);
  endtask
  function automatic int angle(int cfg, int c);
    int v = cfg == 1 ? c * 2 : cfg == 2 ? (c - 'h333) * 5 / 4 : c;
    return 'hfff - (v < 0 ? 0 : v > 'hfff ? 'hfff : v);
  endfunction
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    final_report;
  end
  initial begin
    n = $urandom(32'hb61cd5a4);
    cyc(19);
    @(posedge i_clock) i_rst_n <= 1;
    acc(0, 16'h10a2, 0);
    chk("chan_en", 16'h003f, o_reg_rdata);
    acc(0, 16'h2000, 0);
    chk("err", 1, o_reg_err);
    for (k = 0; k < 2; k++) begin
      @(posedge i_clock) i_firmware_kick <= !k;
      cyc(k * 60 + 1);
      n = 0;
      repeat (48) begin
        h = o_system_healthy_led;
        cyc(1);
        n += (h !== o_system_healthy_led);
      end
      chk("toggles", k ? 0 : 6, n);
    end
    repeat (4) begin
      @(posedge i_clock) {i_fault_active, i_pll_locked} <= 2'($urandom);
      cyc(2);
      chk("fault", i_fault_active, o_fault_led);
      chk("sync", !i_pll_locked, o_line_sync_loss_led);
    end
    $display("Status test done");
    foreach (md[k]) begin
      acc(1, 16'h1000, md[k]);
      cyc(2);
      chk("kind", kd[k], o_mode_kind);
      chk("multi", md[k] == 6 || md[k] == 7, o_multi_controller);
    end
    k = $urandom & 'h3f;
    acc(1, 16'h10a2, k);
    cyc(3);
    chk("gate", k, o_gate_enable);
    @(posedge i_clock) i_fast_inhibit_pin <= 1;
    cyc(5);
    chk("inhibit", 1, o_inhibit_led);
    @(posedge i_clock) {i_fast_inhibit_pin, i_soft_inhibit_pin} <= 4'h7;
    acc(1, 16'h1020, 1);
    k = $urandom & 'hfff;
    acc(1, 16'h0005, k);
    cyc(3);
    chk("angle0", 'hfff - k, o_firing_angle0);
    chk("angle1", 'hfff, o_firing_angle1);
    chk("soft_off", 0, o_inhibit_led);
    acc(1, 16'h1020, 0);
    for (n = 0; n < 4; n++) begin
      @(posedge i_clock) lvl <= n == 2 ? 12'h333 : 12'($urandom);
      acc(1, 16'h1001, n);
      cyc(4);
      chk("angle0", angle(n, lvl), o_firing_angle0);
    end
    acc(1, 16'h1021, 16'h0014);
    @(posedge i_clock) i_ain_select_pin <= 1;
    cyc(5);
    chk("angle0", lvl, o_firing_angle0);
    $display("Mode and angle test done");
    acc(1, 16'h1000, 6);
    acc(1, 16'h1010, 7);
    acc(1, 16'h10a2, 16'h3f);
    cyc(2);
    chk("angle2", 'hfff - lvl, o_firing_angle2);
    foreach (pat[k]) begin
      @(posedge i_clock) i_soft_inhibit_pin <= pat[k];
      cyc(60);
      chk("gate", ge[k], o_gate_enable);
      n = 0;
      repeat (140) begin
        cyc(1);
        if (o_inhibit_led === 1'b1) n++;
      end
      chk("lit", lit[k], n);
    end
    $display("Blink test done");
    final_report;
  end
endmodule // tb
bind tfm_firing_status tfm_chk tfm_chk_i (.*);
`default_nettype wire
